// ---- gate_drive_pkg.sv ----
// Constants, types and register map for the three-phase gate drive logic.
// Assumes a single 100 MHz core clock and a classic Wishbone register bus.
// Behaviour
// RQ1: Six gate outputs, high and low per phase, each driven by its own input.
// RQ2: Each phase accepts its own independent PWM command pair.
// RQ3: Two shared chop inputs give high-side, low-side or fast-decay chopping.
// RQ4: Faults are reported to the controller on two flag outputs.
// RQ5: Fault details sit in a register, read out serially over the flags.
// RQ6: Stop-on-fault input decides whether device or controller acts on faults; undervoltage kills the outputs regardless.
// RQ7: Top-off pump of a phase runs only after its high side is on.
// RQ8: Low gate high turns low switch on; low turns it off.
// RQ9: High gate high turns high switch on; low turns it off.
// RQ10: Resistor mode inserts a programmed dead interval between complementary outputs.
// RQ11: Logic-supply mode uses a default dead interval of 6 us.
// RQ12: Ground mode disables dead time; outputs follow input timing.
// RQ13: In ground mode the controller must avoid shorting the supply.
// RQ14: Never both outputs of a phase, except ground mode with override high.
// RQ15: High chop low turns active high sides off, complementary low sides on.
// RQ16: Low chop low turns active low sides off, complementary high sides on.
// RQ17: Coast low forces all six outputs low, faults stay latched.
// RQ18: Phase, chop and coast inputs are synchronised before lockout logic.
// RQ19: Dead interval counted in clock cycles from the complementary output falling.
package gate_drive_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS       = 10;
	localparam int unsigned DEAD_DEFAULT_NS     = 6000;
	localparam int unsigned DEAD_DEFAULT_CYCLES = DEAD_DEFAULT_NS / CLK_PERIOD_NS;
	localparam int unsigned DEAD_W              = 16;
	localparam logic [15:0] DEAD_DEFAULT_COUNT  = 16'(DEAD_DEFAULT_CYCLES);
	localparam logic [15:0] RES_DEAD_RESET      = 16'h0064;

	////////////////////////////////////////////////////////////////////////////////
	// Dead-time pin modes
	localparam logic [1:0] DT_GROUND   = 2'h0;
	localparam logic [1:0] DT_RESISTOR = 2'h1;
	localparam logic [1:0] DT_LOGIC    = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS   = 8'h08;
	localparam logic [7:0] FAULT_OFS  = 8'h0C;
	localparam logic [7:0] STATE_OFS  = 8'h10;

	localparam int unsigned CTRL_COUNT_LSB = 0;
	localparam int unsigned CTRL_COAST_BIT = 16;

	localparam int unsigned EVT_W          = 3;
	localparam int unsigned EVT_FAULT_BIT  = 0;
	localparam int unsigned EVT_LOCK_BIT   = 1;
	localparam int unsigned EVT_COAST_BIT  = 2;
	localparam logic [2:0]  MASK_RESET     = 3'h0;

	localparam int unsigned FAULT_W        = 8;
	localparam int unsigned FAULT_UV_BIT   = 0;
	localparam int unsigned FAULT_OT_BIT   = 1;
	localparam int unsigned FAULT_SHORT_LSB = 2;
	localparam int unsigned FAULT_STOP_BIT = 8;
	localparam logic [2:0]  READ_LAST_BIT  = 3'h7;

	localparam int unsigned SYNC_W         = 24;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		RD_IDLE  = 3'b001,
		RD_SHIFT = 3'b010,
		RD_DONE  = 3'b100
	} fault_read_e;

	typedef struct packed {
		logic high_chop;
		logic low_chop;
		logic coast_n;
		logic override;
	} chop_s;

	typedef struct packed {
		logic high;
		logic low;
	} gate_pair_s;

endpackage : gate_drive_pkg

// ---- sync_bits.sv ----
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no word coherence is implied.
`timescale 1ns/1ps
module sync_bits #(
	parameter int unsigned W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : sync_bits

// ---- phase_drive.sv ----
// One bridge phase: command decode, lockout, dead interval, top-off pump gate.
// Assumes synchronised inputs and a fixed dead-time mode per operating period.
`timescale 1ns/1ps
module phase_drive (
	input  wire logic                     core_clk,
	input  wire logic                     reset_n,
	input  wire logic                     cmd_high,
	input  wire logic                     cmd_low,
	input  wire gate_drive_pkg::chop_s    chop,
	input  wire logic [1:0]               dead_mode,
	input  wire logic [15:0]              res_dead_count,
	input  wire logic                     kill,
	output gate_drive_pkg::gate_pair_s    gate,
	output logic                          pump_en,
	output logic                          lockout_evt
);

	logic        want_h;
	logic        want_l;
	logic        dt_on;
	logic        high_next;
	logic        low_next;
	logic [15:0] dead_len;
	logic [15:0] dead_load;
	logic [15:0] dead_cnt_reg;

	always_comb begin
		want_h = 1'b0;
		want_l = 1'b0;
		case ({cmd_high, cmd_low})
			2'b10: begin
				want_h = chop.high_chop; // RQ15
				want_l = ~chop.high_chop; // RQ15
			end
			2'b01: begin
				want_h = ~chop.low_chop; // RQ16
				want_l = chop.low_chop; // RQ16
			end
			2'b11: begin
				if (dead_mode == gate_drive_pkg::DT_GROUND) begin
					case ({chop.high_chop, chop.low_chop})
						2'b10: want_h = 1'b1;
						2'b01: want_l = 1'b1;
						2'b11: begin
							want_h = chop.override; // RQ14
							want_l = chop.override; // RQ14
						end
						default: ;
					endcase
				end
			end
			default: ;
		endcase
		if (!chop.coast_n || kill) begin
			want_h = 1'b0; // RQ17
			want_l = 1'b0; // RQ17
		end
	end

	assign dt_on = (dead_mode != gate_drive_pkg::DT_GROUND); // RQ12
	assign dead_len = (dead_mode == gate_drive_pkg::DT_RESISTOR) ? res_dead_count // RQ10
		: gate_drive_pkg::DEAD_DEFAULT_COUNT; // RQ11
	assign dead_load = (dead_len == 16'h0000) ? 16'h0000 : dead_len - 16'h0001; // RQ19

	always_comb begin
		if (dt_on) begin
			high_next = want_h & (gate.high | (~gate.low & (dead_cnt_reg == 16'h0000))); // RQ14
			low_next  = want_l & (gate.low | (~gate.high & (dead_cnt_reg == 16'h0000))); // RQ14
		end else begin
			high_next = want_h; // RQ12
			low_next  = want_l; // RQ12
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gate <= '0;
		end else begin
			gate.high <= high_next; // RQ9
			gate.low  <= low_next; // RQ8
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dead_cnt_reg <= 16'h0000;
		end else if ((gate.high & ~high_next) | (gate.low & ~low_next)) begin
			dead_cnt_reg <= dead_load; // RQ19
		end else if (dead_cnt_reg != 16'h0000) begin
			dead_cnt_reg <= dead_cnt_reg - 16'h0001; // RQ19
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pump_en     <= 1'b0;
			lockout_evt <= 1'b0;
		end else begin
			pump_en     <= gate.high & high_next; // RQ7
			lockout_evt <= cmd_high & cmd_low & ~(want_h | want_l) & chop.coast_n & ~kill;
		end
	end

endmodule : phase_drive

// ---- gate_drive_top.sv ----
// Three-phase gate drive control with fault flags, serial fault word and Wishbone registers.
// Assumes a 100 MHz core clock; analog fault detectors deliver level inputs.
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module gate_drive_top (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [2:0]  phase_high_cmd,
	input  wire logic [2:0]  phase_low_cmd,
	input  wire logic        high_side_chop_in,
	input  wire logic        low_side_chop_in,
	input  wire logic        coast_n,
	input  wire logic        cross_conduction_override,
	input  wire logic [1:0]  dead_time_set_pin,
	input  wire logic        stop_on_fault,
	input  wire logic        fault_clear_n,
	input  wire logic        fault_read_en,
	input  wire logic        fault_read_shift,
	input  wire logic        fault_uv,
	input  wire logic        fault_ot,
	input  wire logic [5:0]  fault_short,
	output logic      [2:0]  high_side_gate_out,
	output logic      [2:0]  low_side_gate_out,
	output logic      [2:0]  topoff_pump_en,
	output logic             fault_flag_one,
	output logic             fault_flag_two,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation
	logic [gate_drive_pkg::SYNC_W-1:0] raw_in;
	logic [gate_drive_pkg::SYNC_W-1:0] sync_in;
	logic [2:0]                        s_high_cmd;
	logic [2:0]                        s_low_cmd;
	gate_drive_pkg::chop_s             s_chop;
	logic [1:0]                        s_dead_mode;
	logic                              s_esf;
	logic                              s_clear_n;
	logic                              s_read_en;
	logic                              s_read_shift;
	logic                              s_uv;
	logic                              s_ot;
	logic [5:0]                        s_short;

	assign raw_in = {phase_high_cmd, phase_low_cmd, high_side_chop_in, low_side_chop_in,
		coast_n, cross_conduction_override, dead_time_set_pin, stop_on_fault,
		fault_clear_n, fault_read_en, fault_read_shift, fault_uv, fault_ot, fault_short};

	sync_bits #(
		.W (gate_drive_pkg::SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in (raw_in),
		.sync_out (sync_in)
	); // RQ18

	assign {s_high_cmd, s_low_cmd, s_chop, s_dead_mode, s_esf, s_clear_n, s_read_en,
		s_read_shift, s_uv, s_ot, s_short} = sync_in;

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [15:0]                       res_dead_reg;
	logic                              soft_coast_reg;
	logic [gate_drive_pkg::EVT_W-1:0]  status_reg;
	logic [gate_drive_pkg::EVT_W-1:0]  mask_reg;
	logic                              ack_reg;
	logic [31:0]                       dat_reg;
	logic                              bus_take;
	logic                              bus_write;
	logic                              rd_status;
	logic [31:0]                       wmask;
	logic [31:0]                       ctrl_word;
	logic [31:0]                       rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// Fault state
	logic [gate_drive_pkg::FAULT_W-1:0] fault_now;
	logic [gate_drive_pkg::FAULT_W-1:0] fault_reg;
	logic                               stop_reg;
	logic                               stop_set;
	logic                               fault_clear;
	logic                               kill;
	logic                               coast_d_reg;
	logic                               shift_d_reg;
	logic                               shift_rise;
	gate_drive_pkg::fault_read_e        rd_state_reg;
	logic [gate_drive_pkg::FAULT_W-1:0] rd_shift_reg;
	logic [2:0]                         rd_cnt_reg;
	logic                               ff1_reg;
	logic                               ff2_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Phases
	gate_drive_pkg::gate_pair_s gate [3];
	logic [2:0]                 lockout;
	logic [gate_drive_pkg::EVT_W-1:0] evt;

	assign kill = stop_reg | s_uv | soft_coast_reg; // RQ6

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_phase
			phase_drive u_phase (
				.core_clk       (core_clk),
				.reset_n        (reset_n),
				.cmd_high       (s_high_cmd[gi]), // RQ2
				.cmd_low        (s_low_cmd[gi]), // RQ2
				.chop           (s_chop), // RQ3
				.dead_mode      (s_dead_mode),
				.res_dead_count (res_dead_reg),
				.kill           (kill),
				.gate           (gate[gi]),
				.pump_en        (topoff_pump_en[gi]),
				.lockout_evt    (lockout[gi])
			);
			assign high_side_gate_out[gi] = gate[gi].high; // RQ1
			assign low_side_gate_out[gi]  = gate[gi].low; // RQ1
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Fault latching
	assign fault_now = {s_short, s_ot, s_uv};
	assign fault_clear = ~s_clear_n;
	assign stop_set = s_esf & (s_ot | (|s_short)); // RQ6

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= fault_now | (fault_clear ? '0 : fault_reg); // RQ5
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_reg <= 1'b0;
		end else begin
			stop_reg <= stop_set | (stop_reg & ~fault_clear); // RQ6
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial fault word readout over the flags
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_d_reg <= 1'b0;
			coast_d_reg <= 1'b0;
		end else begin
			shift_d_reg <= s_read_shift;
			coast_d_reg <= s_chop.coast_n;
		end
	end

	assign shift_rise = s_read_shift & ~shift_d_reg;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_state_reg <= gate_drive_pkg::RD_IDLE;
			rd_shift_reg <= '0;
			rd_cnt_reg   <= 3'h0;
		end else begin
			case (rd_state_reg)
				gate_drive_pkg::RD_IDLE: begin
					if (s_read_en) begin
						rd_shift_reg <= fault_reg; // RQ5
						rd_cnt_reg   <= 3'h0;
						rd_state_reg <= gate_drive_pkg::RD_SHIFT;
					end
				end
				gate_drive_pkg::RD_SHIFT: begin
					if (!s_read_en) begin
						rd_state_reg <= gate_drive_pkg::RD_IDLE;
					end else if (shift_rise) begin
						rd_shift_reg <= {rd_shift_reg[gate_drive_pkg::FAULT_W-2:0], 1'b0}; // RQ5
						rd_cnt_reg   <= rd_cnt_reg + 3'h1;
						if (rd_cnt_reg == gate_drive_pkg::READ_LAST_BIT) begin
							rd_state_reg <= gate_drive_pkg::RD_DONE;
						end
					end
				end
				gate_drive_pkg::RD_DONE: begin
					if (!s_read_en) begin
						rd_state_reg <= gate_drive_pkg::RD_IDLE;
					end
				end
				default: rd_state_reg <= gate_drive_pkg::RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ff1_reg <= 1'b0;
			ff2_reg <= 1'b0;
		end else begin
			case (rd_state_reg)
				gate_drive_pkg::RD_SHIFT: begin
					ff1_reg <= rd_shift_reg[gate_drive_pkg::FAULT_W-1]; // RQ5
					ff2_reg <= 1'b1;
				end
				gate_drive_pkg::RD_DONE: begin
					ff1_reg <= 1'b0;
					ff2_reg <= 1'b1;
				end
				default: begin
					ff1_reg <= stop_reg | (|fault_reg[gate_drive_pkg::FAULT_W-1:1]); // RQ4
					ff2_reg <= fault_reg[gate_drive_pkg::FAULT_UV_BIT]; // RQ4
				end
			endcase
		end
	end

	assign fault_flag_one = ff1_reg;
	assign fault_flag_two = ff2_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Events and interrupt
	always_comb begin
		evt = '0;
		evt[gate_drive_pkg::EVT_FAULT_BIT] = |(fault_now & ~fault_reg);
		evt[gate_drive_pkg::EVT_LOCK_BIT]  = |lockout;
		evt[gate_drive_pkg::EVT_COAST_BIT] = coast_d_reg & ~s_chop.coast_n;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= evt | (rd_status ? '0 : status_reg);
		end
	end

	assign irq = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave
	assign bus_take  = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign bus_write = bus_take & wb_we_i;
	assign rd_status = bus_take & ~wb_we_i & (wb_adr_i == gate_drive_pkg::STATUS_OFS);
	assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign ctrl_word = {15'h0000, soft_coast_reg, res_dead_reg};

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			res_dead_reg   <= gate_drive_pkg::RES_DEAD_RESET;
			soft_coast_reg <= 1'b0;
			mask_reg       <= gate_drive_pkg::MASK_RESET;
		end else if (bus_write) begin
			case (wb_adr_i)
				gate_drive_pkg::CTRL_OFS: begin
					res_dead_reg   <= (res_dead_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
					soft_coast_reg <= wb_sel_i[2] ? wb_dat_i[gate_drive_pkg::CTRL_COAST_BIT]
						: soft_coast_reg;
				end
				gate_drive_pkg::MASK_OFS: begin
					if (wb_sel_i[0]) begin
						mask_reg <= wb_dat_i[gate_drive_pkg::EVT_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		case (wb_adr_i)
			gate_drive_pkg::CTRL_OFS:   rd_word = ctrl_word;
			gate_drive_pkg::STATUS_OFS: rd_word = {29'h0, status_reg};
			gate_drive_pkg::MASK_OFS:   rd_word = {29'h0, mask_reg};
			gate_drive_pkg::FAULT_OFS:  rd_word = {23'h0, stop_reg, fault_reg};
			gate_drive_pkg::STATE_OFS:  rd_word = {21'h0, topoff_pump_en, s_dead_mode,
				low_side_gate_out, high_side_gate_out};
			default:                    rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_take;
			if (bus_take && !wb_we_i) begin
				dat_reg <= rd_word;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

endmodule : gate_drive_top

// ---- motor_ctrl_model.sv ----
// Model of the motor controller that drives the per-phase command pairs.
// Assumes the bench posts wanted commands; they reach the pins one edge later, two on a ground-mode side swap.
`timescale 1ns/1ps
module motor_ctrl_model (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       ground_mode,
	input  wire logic [2:0] want_high,
	input  wire logic [2:0] want_low,
	output logic      [2:0] phase_high_cmd,
	output logic      [2:0] phase_low_cmd
);
	logic [2:0] flip;

	// Side swap without dead time passes through off first
	assign flip = ground_mode ? ((phase_high_cmd & want_low & ~want_high)
		| (phase_low_cmd & want_high & ~want_low)) : 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_high_cmd <= 3'h0;
			phase_low_cmd  <= 3'h0;
		end else begin
			phase_high_cmd <= want_high & ~flip;
			phase_low_cmd  <= want_low & ~flip;
		end
	end
endmodule : motor_ctrl_model

// ---- gate_drive_monitor.sv ----
// Concurrent checks on the gate drive top ports.
// Assumes one core clock domain and 3-cycle input-to-gate latency.
`timescale 1ns/1ps
module gate_drive_monitor (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [2:0]  phase_high_cmd,
	input wire logic [2:0]  phase_low_cmd,
	input wire logic        high_side_chop_in,
	input wire logic        low_side_chop_in,
	input wire logic        coast_n,
	input wire logic        cross_conduction_override,
	input wire logic [1:0]  dead_time_set_pin,
	input wire logic        fault_uv,
	input wire logic [2:0]  high_side_gate_out,
	input wire logic [2:0]  low_side_gate_out,
	input wire logic [2:0]  topoff_pump_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [9:0] gap_reg;
	logic       gates_off;

	assign gates_off = (high_side_gate_out == 3'h0) && (low_side_gate_out == 3'h0);

	// Edges since the phase A low gate was last on
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			gap_reg <= 10'h3FF;
		else if (low_side_gate_out[0])
			gap_reg <= 10'h0;
		else if (gap_reg != 10'h3FF)
			gap_reg <= gap_reg + 10'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence req_seen;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	ack_timing_a: assert property (req_seen |=> ack_pulse)
		else $error("ack not a single pulse one cycle after request");
	unmapped_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h10
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	cross_cond_a: assert property (|(high_side_gate_out & low_side_gate_out)
		|-> $past(cross_conduction_override, 3) && $past(dead_time_set_pin, 3) == 2'h0)
		else $error("both gates of a phase on without override");
	lockout_off_a: assert property ($past(dead_time_set_pin, 3) != 2'h0
		&& $past(phase_high_cmd[0] & phase_low_cmd[0], 3)
		|-> !high_side_gate_out[0] && !low_side_gate_out[0])
		else $error("lockout did not disable phase");
	coast_off_a: assert property (!$past(coast_n, 3) |-> gates_off)
		else $error("coast did not force gates low");
	high_chop_a: assert property ($past(phase_high_cmd[0] & !phase_low_cmd[0]
		& !high_side_chop_in, 3) |-> !high_side_gate_out[0])
		else $error("high chop left high gate on");
	low_chop_a: assert property ($past(phase_low_cmd[0] & !phase_high_cmd[0]
		& !low_side_chop_in, 3) |-> !low_side_gate_out[0])
		else $error("low chop left low gate on");
	uv_off_a: assert property ($past(fault_uv, 3) && $past(fault_uv, 4) |-> gates_off)
		else $error("undervoltage did not force gates low");
	pump_after_a: assert property (topoff_pump_en[0]
		|-> high_side_gate_out[0] && $past(high_side_gate_out[0]))
		else $error("pump enabled before high gate on");
	dead_default_a: assert property ($rose(high_side_gate_out[0]) && $past(dead_time_set_pin[1], 3)
		|-> gap_reg >= 10'(gate_drive_pkg::DEAD_DEFAULT_CYCLES))
		else $error("default dead interval too short");
endmodule : gate_drive_monitor

bind gate_drive_top gate_drive_monitor gate_drive_monitor_inst (.*);

// ---- tb.sv ----
// Self-checking bench for the three-phase gate drive top.
// Assumes a 100 MHz core clock, classic Wishbone and the controller model.
`timescale 1ns/1ps
module tb;
	logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [2:0] phase_high_cmd, phase_low_cmd, want_high, want_low;
	logic high_side_chop_in, low_side_chop_in, coast_n, cross_conduction_override;
	logic [1:0] dead_time_set_pin;
	logic stop_on_fault, fault_clear_n, fault_read_en, fault_read_shift, fault_uv, fault_ot;
	logic [5:0] fault_short;
	logic [2:0] high_side_gate_out, low_side_gate_out, topoff_pump_en;
	logic fault_flag_one, fault_flag_two, irq;
	int miscompares, num_checks, cycles;

	gate_drive_top gate_drive_top_inst (.*);
	motor_ctrl_model motor_ctrl_model_inst (.core_clk(core_clk), .reset_n(reset_n),
		.ground_mode(dead_time_set_pin == 2'h0), .want_high(want_high), .want_low(want_low),
		.phase_high_cmd(phase_high_cmd), .phase_low_cmd(phase_low_cmd));

	////////////////////////////////////////////////////////////////////////////////
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do
			@(posedge core_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_access

	function automatic logic [31:0] gates();
		return {26'h0, high_side_gate_out, low_side_gate_out};
	endfunction : gates

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		check_word({27'h0, topoff_pump_en, fault_flag_one, fault_flag_two, irq}, 32'h0);
		check_word(gates(), 32'h0);
		wb_access(1'b0, gate_drive_pkg::CTRL_OFS, 32'h0);
		check_word(rd, {16'h0, gate_drive_pkg::RES_DEAD_RESET});
		wb_access(1'b0, gate_drive_pkg::MASK_OFS, 32'h0);
		check_word(rd, 32'h0);
		wb_access(1'b0, 8'h40, 32'h0);
		check_word(rd, 32'h0);
	endtask : test_reset

	task automatic test_dead(input logic [1:0] mode, input logic [15:0] cnt, input int dead);
		int n, t_low = 0, t_high = 0, t_pump = 0;
		wb_access(1'b1, gate_drive_pkg::CTRL_OFS, {16'h0, cnt});
		dead_time_set_pin <= mode;
		want_high <= 3'h0;
		want_low <= 3'h1;
		tick(700);
		want_high <= 3'h1;
		want_low <= 3'h0;
		for (n = 1; n < 700; n++) begin
			@(posedge core_clk);
			if (t_low == 0 && low_side_gate_out[0] === 1'b0)
				t_low = n;
			if (t_high == 0 && high_side_gate_out[0] === 1'b1)
				t_high = n;
			if (t_pump == 0 && topoff_pump_en[0] === 1'b1)
				t_pump = n;
		end
		check_word(32'(t_low), 32'h5);
		check_word(32'(t_high), 32'(5 + dead));
		check_word(32'(t_pump), 32'(6 + dead));
		want_low <= 3'h1;
		tick(8);
		check_word(gates(), 32'h0);
		want_high <= 3'h0;
		want_low <= 3'h0;
		tick(4);
		check_word({31'h0, irq}, 32'h0);
		wb_access(1'b0, gate_drive_pkg::STATUS_OFS, 32'h0);
		check_word(rd & 32'h2, 32'h2);
		wb_access(1'b0, gate_drive_pkg::STATUS_OFS, 32'h0);
		check_word(rd & 32'h2, 32'h0);
	endtask : test_dead

	task automatic test_ground();
		int c;
		dead_time_set_pin <= 2'h0;
		cross_conduction_override <= 1'b1;
		want_high <= 3'h7;
		want_low <= 3'h7;
		tick(8);
		check_word(gates(), 32'h3F);
		wb_access(1'b0, gate_drive_pkg::STATE_OFS, 32'h0);
		check_word(rd, 32'h73F);
		cross_conduction_override <= 1'b0;
		tick(8);
		check_word(gates(), 32'h0);
		want_high <= 3'h1;
		want_low <= 3'h2;
		for (c = 0; c < 4; c++) begin
			{high_side_chop_in, low_side_chop_in} <= 2'(c);
			tick(8);
			check_word(gates(), {26'h0, 1'b0, ~c[0], c[1], 1'b0, c[0], ~c[1]});
		end
	endtask : test_ground

	task automatic test_fault();
		want_high <= 3'h1;
		want_low <= 3'h0;
		stop_on_fault <= 1'b1;
		fault_ot <= 1'b1;
		fault_short <= 6'h20;
		tick(6);
		fault_ot <= 1'b0;
		fault_short <= 6'h0;
		tick(6);
		check_word({30'h0, fault_flag_one, gates() != 32'h0}, 32'h2);
		coast_n <= 1'b0;
		tick(6);
		check_word({31'h0, irq}, 32'h0);
		wb_access(1'b1, gate_drive_pkg::MASK_OFS, 32'h4);
		tick(2);
		check_word({31'h0, irq}, 32'h1);
		wb_access(1'b0, gate_drive_pkg::STATUS_OFS, 32'h0);
		check_word(rd & 32'h4, 32'h4);
		tick(2);
		check_word({31'h0, irq}, 32'h0);
		coast_n <= 1'b1;
		wb_access(1'b0, gate_drive_pkg::FAULT_OFS, 32'h0);
		check_word(rd, 32'h182);
		fault_read_en <= 1'b1;
		tick(6);
		check_word({30'h0, fault_flag_two, fault_flag_one}, 32'h3);
		fault_read_shift <= 1'b1;
		tick(6);
		check_word({31'h0, fault_flag_one}, 32'h0);
		fault_read_shift <= 1'b0;
		fault_read_en <= 1'b0;
		fault_clear_n <= 1'b0;
		tick(4);
		fault_clear_n <= 1'b1;
		tick(8);
		check_word({30'h0, fault_flag_one, high_side_gate_out[0]}, 32'h1);
		fault_uv <= 1'b1;
		tick(8);
		check_word({30'h0, fault_flag_two, high_side_gate_out[0]}, 32'h2);
		fault_uv <= 1'b0;
	endtask : test_fault

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, stop_on_fault} = 6'h0;
		{fault_read_en, fault_read_shift, fault_uv, fault_ot, cross_conduction_override} = 5'h0;
		{high_side_chop_in, low_side_chop_in, coast_n, fault_clear_n} = 4'hF;
		{wb_adr_i, wb_dat_i, fault_short, want_high, want_low} = 52'h0;
		wb_sel_i = 4'hF;
		dead_time_set_pin = 2'h2;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		tick(1);
		test_reset();
		test_dead(2'h2, 16'h5, gate_drive_pkg::DEAD_DEFAULT_CYCLES);
		test_dead(2'h1, 16'h5, 5);
		test_dead(2'h1, 16'h0, 1);
		test_ground();
		test_fault();
		stop_test();
	end
endmodule : tb
